// >>> common/bus_cond_if.sv
// bus condition signals from the line sampler to the slave core
// assumes one clock; all signals are one-cycle pulses except sda
`timescale 1ns/1ps
interface bus_cond_if;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic sda;

  modport det  (output scl_rise, output scl_fall, output start, output stop, output sda);
  modport core (input scl_rise, input scl_fall, input start, input stop, input sda);
endinterface

// >>> common/two_wire_defs.svh
// offsets, field positions, reset values and status codes of the two-wire slave
// assumes inclusion by bare name from the package and the assertion module
`ifndef TWO_WIRE_DEFS_SVH
`define TWO_WIRE_DEFS_SVH

// register offsets on the plain register port
`define TW_OFF_DATA     3'h0
`define TW_OFF_STATUS   3'h1
`define TW_OFF_OWN_ADDR 3'h2
`define TW_OFF_CTRL     3'h3

// interface_control field positions
`define TW_CTRL_FLAG    7
`define TW_CTRL_ACK_EN  6
`define TW_CTRL_STA     5
`define TW_CTRL_STO     4
`define TW_CTRL_WCOL    3
`define TW_CTRL_EN      2
`define TW_CTRL_IRQ_EN  0

// reset values
`define TW_RST_DATA     8'hff
`define TW_RST_OWN_ADDR 8'hfe
`define TW_RST_CODE     8'hf8

// status codes, prescaler bits read as zero; then general-call address and bit count
`define TW_ST_SR_ADDR   8'h60
`define TW_ST_SR_ARB    8'h68
`define TW_ST_GC_ADDR   8'h70
`define TW_ST_GC_ARB    8'h78
`define TW_ST_SR_ACK    8'h80
`define TW_ST_SR_NACK   8'h88
`define TW_ST_GC_ACK    8'h90
`define TW_ST_GC_NACK   8'h98
`define TW_ST_STOP      8'ha0
`define TW_ST_ST_ADDR   8'ha8
`define TW_ST_ST_ARB    8'hb0
`define TW_ST_ST_ACK    8'hb8
`define TW_ST_ST_NACK   8'hc0
`define TW_ST_ST_LAST   8'hc8
`define TW_ST_NONE      8'hf8
`define TW_GC_ADDR      7'h00
`define TW_BITS         4'h8

`endif

// >>> common/two_wire_pkg.sv
// types shared by the two-wire slave modules
// assumes the defs header sits on the include path
package two_wire_pkg;
  `include "two_wire_defs.svh"

  typedef enum logic [2:0] {
    IDLE_S,
    ADDR_S,
    ADDR_ACK_S,
    RX_DATA_S,
    RX_ACK_S,
    TX_DATA_S,
    TX_ACK_S,
    DONE_S
  } slave_state_t;
endpackage

// >>> dv/bus_master_model.sv
// behavioural bus master pulling the open-drain clock and data lines
// assumes the bench resolves the wired lines with pull-ups and feeds them back
`timescale 1ns/1ps
module bus_master_model (
  // clock
  input  wire logic i_ref_clk,
  // resolved lines
  input  wire logic i_scl,
  input  wire logic i_sda,
  // pull-down controls
  output logic      o_scl_low,
  output logic      o_sda_low
);
  initial begin
    o_scl_low = 1'b0;
    o_sda_low = 1'b0;
  end
  // stretches that outlast the bound are counted and end in a failed verdict
  int n_stuck = 0;
  task automatic w(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask
  // waits out a slave stretch; bounded so a stuck line is counted in n_stuck
  task automatic scl_up();
    int k;
    k = 0;
    o_scl_low <= 1'b0;
    w(1);
    while (!i_scl && k < 4000) begin
      w(1);
      k++;
    end
    if (k >= 4000) n_stuck++;
  endtask
  // clock low is 8 cycles so the slave sees every fall before the next rise
  task automatic bit_io(input logic b, output logic r);
    o_sda_low <= !b;
    w(4);
    scl_up();
    w(2);
    r = i_sda;
    w(2);
    o_scl_low <= 1'b1;
    w(4);
  endtask
  task automatic start();
    o_sda_low <= 1'b0;
    w(4);
    scl_up();
    w(4);
    o_sda_low <= 1'b1;
    w(4);
    o_scl_low <= 1'b1;
    w(4);
  endtask
  task automatic stop();
    o_sda_low <= 1'b1;
    w(4);
    scl_up();
    w(4);
    o_sda_low <= 1'b0;
    w(4);
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic get_byte(output logic [7:0] d, input logic mack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(!mack, r);
  endtask
endmodule

// >>> dv/two_wire_slave_asserts.sv
// concurrent checks on the two-wire slave top ports
// assumes one clock, synchronous active-low reset, lines resolved outside
`timescale 1ns/1ps
`include "two_wire_defs.svh"
module two_wire_slave_asserts #(
  parameter int ADDR_W = 3
) (
  // clock, reset and register port
  input wire logic              i_ref_clk, i_nrst, i_wr, i_rd,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [7:0]        i_wdata, o_rdata,
  // bus pins and system
  input wire logic              i_scl, o_scl_o, o_scl_oe, i_sda, o_sda_o, o_sda_oe,
  input wire logic              i_arb_lost, i_deep_sleep, o_wake_req, o_start_issue
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  logic ctl_wr;
  assign ctl_wr = i_wr && i_addr == ADDR_W'(`TW_OFF_CTRL);

  open_drain_a: assert property (o_scl_o == 1'b0 && o_sda_o == 1'b0)
    else $error("pin output level not low");
  // the clear may take one or two edges to reach the pin, so both are exempt
  stretch_hold_a: assert property (o_scl_oe && !ctl_wr && !$past(ctl_wr)
    |=> o_scl_oe)
    else $error("clock stretch released without a control write");
  stretch_drop_a: assert property (o_scl_oe && ctl_wr && i_wdata[`TW_CTRL_FLAG]
    |-> ##[1:2] !o_scl_oe)
    else $error("clock stretch held after flag clear");
  stretch_rise_a: assert property ($rose(o_scl_oe) |-> !$past(i_scl))
    else $error("clock stretch began while clock was high");
  sda_rise_a: assert property ($rose(o_sda_oe) |-> !$past(i_scl))
    else $error("data pulled low while clock high");
  sda_still_a: assert property (i_scl && $past(i_scl) |-> $stable(o_sda_oe))
    else $error("data drive changed during clock high");
  start_pulse_a: assert property (o_start_issue |=> !o_start_issue)
    else $error("start issue longer than one cycle");
  wake_sleep_a: assert property ($rose(o_wake_req) |-> $past(i_deep_sleep))
    else $error("wake request outside deep sleep");
  stretch_code_a: assert property ($past(i_rd) && $past(o_scl_oe) &&
    $past(i_addr) == ADDR_W'(`TW_OFF_STATUS) |-> o_rdata[7:3] != 5'h1f)
    else $error("no valid status while stretching");
endmodule

bind two_wire_slave two_wire_slave_asserts #(.ADDR_W(ADDR_W)) chk (.i_ref_clk, .i_nrst,
  .i_wr, .i_rd, .i_addr, .i_wdata, .o_rdata, .i_scl, .o_scl_o, .o_scl_oe, .i_sda,
  .o_sda_o, .o_sda_oe, .i_arb_lost, .i_deep_sleep, .o_wake_req, .o_start_issue);

// >>> dv/two_wire_slave_tb.sv
// testbench for the two-wire slave: register tasks plus a bus master model
// assumes model tasks start just after a clock edge
`timescale 1ns/1ps
module two_wire_slave_tb import two_wire_pkg::*;;
  logic       i_ref_clk = 1'b0;
  logic       i_nrst = 1'b0;
  logic [2:0] i_addr = 3'h0;
  logic [7:0] i_wdata = 8'h00;
  logic       i_wr = 1'b0, i_rd = 1'b0, i_arb_lost = 1'b0, i_deep_sleep = 1'b0;
  logic [7:0] o_rdata, d;
  logic       o_scl_o, o_scl_oe, o_sda_o, o_sda_oe, o_wake_req, o_start_issue;
  logic       m_scl_low, m_sda_low, i_scl, i_sda, ack;
  int         n_mismatch = 0, checks = 0;
  always #2.5 i_ref_clk = ~i_ref_clk;
  // wired-AND with pull-ups: a released line reads high
  assign i_scl = !(o_scl_oe || m_scl_low);
  assign i_sda = !(o_sda_oe || m_sda_low);
  two_wire_slave #(.ADDR_W(3)) dut (.i_ref_clk, .i_nrst, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_scl, .o_scl_o, .o_scl_oe, .i_sda, .o_sda_o, .o_sda_oe, .i_arb_lost,
    .i_deep_sleep, .o_wake_req, .o_start_issue);
  bus_master_model m (.i_ref_clk, .i_scl, .i_sda, .o_scl_low(m_scl_low), .o_sda_low(m_sda_low));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask
  // status is compared with the prescaler bits masked off
  task automatic step(input logic [7:0] code, input logic ld, input logic [7:0] v,
                      input logic [7:0] ctl);
    logic [7:0] s;
    check({7'h0, o_scl_oe}, 8'h01);
    rd(3'h1, s);
    check(s & 8'hf8, code);
    if (ld) wr(3'h0, v);
    wr(3'h3, ctl);
  endtask
  task automatic addr(input logic [7:0] a, input logic e);
    m.start();
    m.put_byte(a, ack);
    check({7'h0, ack}, {7'h0, e});
  endtask
  task automatic stop_start();
    logic p;
    p = 1'b0;
    fork
      m.stop();
      repeat (40) @(posedge i_ref_clk) if (o_start_issue === 1'b1) p = 1'b1;
    join
    check({7'h0, p}, 8'h01);
  endtask
  task automatic finish_test();
    n_mismatch += m.n_stuck;
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge i_ref_clk);
    n_mismatch++;
    finish_test();
  end
  initial begin
    repeat (2) @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    rd(3'h2, d);
    check(d, 8'hfe);
    rd(3'h3, d);
    check(d, 8'h00);
    rd(3'h5, d);
    check(d, 8'h00);
    wr(3'h1, 8'h03);
    rd(3'h1, d);
    check(d, 8'hfb);
    wr(3'h2, 8'h55);
    rd(3'h2, d);
    check(d, 8'h55);
    wr(3'h3, 8'h44);
    addr(8'h54, 1'b1);
    step(8'h60, 1'b0, 8'h00, 8'hc4);
    m.put_byte(8'ha5, ack);
    step(8'h80, 1'b0, 8'h00, 8'h84);
    rd(3'h0, d);
    check(d, 8'ha5);
    m.put_byte(8'h5a, ack);
    check({7'h0, ack}, 8'h00);
    step(8'h88, 1'b0, 8'h00, 8'he4);
    stop_start();
    wr(3'h3, 8'h44);
    i_deep_sleep <= 1'b1;
    addr(8'h54, 1'b1);
    check({7'h0, o_wake_req}, 8'h01);
    step(8'h60, 1'b0, 8'h00, 8'hc4);
    // the clear lands at the last edge of the write; look one edge later
    @(posedge i_ref_clk);
    check({7'h0, o_wake_req}, 8'h00);
    m.put_byte(8'h77, ack);
    step(8'h80, 1'b0, 8'h00, 8'hc4);
    rd(3'h0, d);
    check(d, 8'h5a);
    m.stop();
    rd(3'h1, d);
    check(d & 8'hf8, 8'ha0);
    wr(3'h3, 8'hc4);
    i_deep_sleep <= 1'b0;
    addr(8'h00, 1'b1);
    step(8'h70, 1'b0, 8'h00, 8'hc4);
    m.put_byte(8'h33, ack);
    step(8'h90, 1'b0, 8'h00, 8'h84);
    m.put_byte(8'h44, ack);
    check({7'h0, ack}, 8'h00);
    step(8'h98, 1'b0, 8'h00, 8'hc4);
    m.stop();
    rd(3'h1, d);
    check(d & 8'hf8, 8'hf8);
    wr(3'h3, 8'h04);
    addr(8'h54, 1'b0);
    m.stop();
    wr(3'h3, 8'h44);
    addr(8'h55, 1'b1);
    step(8'ha8, 1'b1, 8'h3c, 8'hc4);
    m.get_byte(d, 1'b1);
    check(d, 8'h3c);
    step(8'hb8, 1'b1, 8'hc3, 8'h84);
    m.get_byte(d, 1'b1);
    check(d, 8'hc3);
    step(8'hc8, 1'b0, 8'h00, 8'hc4);
    m.get_byte(d, 1'b0);
    check(d, 8'hff);
    m.stop();
    i_arb_lost <= 1'b1;
    addr(8'h55, 1'b1);
    step(8'hb0, 1'b1, 8'h81, 8'hc4);
    i_arb_lost <= 1'b0;
    m.get_byte(d, 1'b0);
    check(d, 8'h81);
    step(8'hc0, 1'b0, 8'h00, 8'hc4);
    // lost arbitration on a write, then a repeated start to the general call
    i_arb_lost <= 1'b1;
    addr(8'h54, 1'b1);
    step(8'h68, 1'b0, 8'h00, 8'hc4);
    addr(8'h00, 1'b1);
    step(8'h78, 1'b0, 8'h00, 8'hc4);
    i_arb_lost <= 1'b0;
    m.stop();
    rd(3'h1, d);
    check(d & 8'hf8, 8'ha0);
    wr(3'h3, 8'hc4);
    finish_test();
  end
endmodule

// >>> logic/bus_cond_detect.sv
// line sampler: finds clock edges and start/stop conditions on the bus
// assumes i_scl and i_sda already synchronous to i_ref_clk
`timescale 1ns/1ps
module bus_cond_detect (
  // clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_nrst,
  // bus lines
  input  wire logic i_scl,
  input  wire logic i_sda,
  // conditions
  bus_cond_if.det   cond
);
  logic scl_reg;
  logic sda_reg;

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
    end else begin
      scl_reg <= i_scl;
      sda_reg <= i_sda;
    end
  end

  // sda moving while scl is high marks start (falling) or stop (rising)
  assign cond.scl_rise = i_scl & ~scl_reg;
  assign cond.scl_fall = ~i_scl & scl_reg;
  assign cond.start    = i_scl & scl_reg & sda_reg & ~i_sda;
  assign cond.stop     = i_scl & scl_reg & ~sda_reg & i_sda;
  assign cond.sda      = i_sda;
endmodule

// >>> logic/two_wire_slave.sv
// two-wire slave core: address match, receive and transmit, status, clock stretch
// assumes synchronous bus inputs, open-drain pads resolved outside, one clock
//
// Functional notes
// [R1] general-call byte acked: post 0x90, ack per enable
// [R2] general-call byte nacked: post 0x98, then unaddressed
// [R3] clear with start request: start when bus free
// [R4] stop or restart while addressed posts 0xA0
// [R5] status codes compare with prescaler bits masked
// [R6] own address upper seven bits, lsb enables call
// [R7] software sets enable and ack, clears start/stop
// [R8] direction bit one selects transmit, else receive
// [R9] address acked sets event flag with status
// [R10] arbitration lost then read-addressed posts 0xB0
// [R11] ack cleared: last byte, then 0xC0 or 0xC8
// [R12] after last byte ignore master, bus reads ones
// [R13] ack enable low ignores own address only; the code also ignores the general call
// [R14] deep sleep still matches address and wakes part
// [R15] after wake hold scl until flag cleared
// [R16] data register not updated during deep sleep
// [R17] own-write byte nacked: post 0x88, then unaddressed
// [R18] read address acked posts 0xA8, byte loaded
// [R19] transmitted byte acked posts 0xB8, reload byte
// [R20] flag set while addressed stretches scl low
`timescale 1ns/1ps
module two_wire_slave
  import two_wire_pkg::*;
#(
  parameter int ADDR_W = 3
) (
  // clock and reset
  input  wire logic              i_ref_clk,
  input  wire logic              i_nrst,
  // register port
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [7:0]        i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [7:0]        o_rdata,
  // bus pins, open drain
  input  wire logic              i_scl,
  output logic                   o_scl_o,
  output logic                   o_scl_oe,
  input  wire logic              i_sda,
  output logic                   o_sda_o,
  output logic                   o_sda_oe,
  // system
  input  wire logic              i_arb_lost,
  input  wire logic              i_deep_sleep,
  output logic                   o_wake_req,
  output logic                   o_start_issue
);
  bus_cond_if c ();

  bus_cond_detect u_det (
    .i_ref_clk (i_ref_clk),
    .i_nrst    (i_nrst),
    .i_scl     (i_scl),
    .i_sda     (i_sda),
    .cond      (c)
  );

  slave_state_t state_reg;
  logic [7:0]   data_reg;
  logic [7:0]   code_reg;
  logic [7:0]   own_slave_address_reg;
  logic [7:0]   shift_reg;
  logic [7:0]   tx_reg;
  logic [7:0]   rdata_reg;
  logic [7:0]   evt_code;
  logic [7:0]   code_shown;
  logic [3:0]   bit_cnt_reg;
  logic [1:0]   presc_reg;
  logic         flag_reg;
  logic         ack_en_reg;
  logic         sta_reg;
  logic         sto_reg;
  logic         wcol_reg;
  logic         en_reg;
  logic         irq_en_reg;
  logic         gc_mode_reg;
  logic         dir_rd_reg;
  logic         rx_ack_reg;
  logic         mack_reg;
  logic         last_reg;
  logic         tx_on_reg;
  logic         sda_drv_reg;
  logic         scl_hold_reg;
  logic         busy_reg;
  logic         start_pend_reg;
  logic         start_issue_reg;
  logic         wake_req_reg;
  logic         low_reg;
  logic         wr_ctrl;
  logic         flag_clr;
  logic         own_hit;
  logic         gc_hit;
  logic         addressed;
  logic         evt_set;
  logic         leaving;

  assign wr_ctrl  = i_wr && (i_addr == ADDR_W'(`TW_OFF_CTRL));
  assign flag_clr = wr_ctrl && i_wdata[`TW_CTRL_FLAG] && flag_reg;

  // ack enable gates both matches, so clearing it isolates the slave
  assign own_hit = en_reg && ack_en_reg &&
                   (shift_reg[7:1] == own_slave_address_reg[7:1]); // see [R6] see [R13]
  assign gc_hit  = en_reg && ack_en_reg && own_slave_address_reg[0] &&
                   (shift_reg[7:1] == `TW_GC_ADDR) && !shift_reg[0]; // see [R6]
  assign addressed = (state_reg == RX_DATA_S) || (state_reg == RX_ACK_S) ||
                     (state_reg == TX_DATA_S) || (state_reg == TX_ACK_S);
  assign leaving   = (state_reg == DONE_S) || (code_reg == `TW_ST_STOP);
  // with the flag low the status shows the idle code
  assign code_shown = flag_reg ? code_reg : `TW_ST_NONE;

  // event decode: which bus moment posts which status code
  always_comb begin
    evt_set  = 1'b0;
    evt_code = code_reg;
    if (c.start || c.stop) begin
      if (addressed) begin
        evt_set  = 1'b1;
        evt_code = `TW_ST_STOP; // see [R4]
      end
    end else if (c.scl_fall) begin
      case (state_reg)
        ADDR_ACK_S: begin
          evt_set = 1'b1; // see [R9]
          if (dir_rd_reg) begin
            evt_code = i_arb_lost ? `TW_ST_ST_ARB : `TW_ST_ST_ADDR; // see [R10] see [R18]
          end else if (gc_mode_reg) begin
            evt_code = i_arb_lost ? `TW_ST_GC_ARB : `TW_ST_GC_ADDR;
          end else begin
            evt_code = i_arb_lost ? `TW_ST_SR_ARB : `TW_ST_SR_ADDR;
          end
        end
        RX_ACK_S: begin
          evt_set = 1'b1;
          if (gc_mode_reg) begin
            evt_code = rx_ack_reg ? `TW_ST_GC_ACK : `TW_ST_GC_NACK; // see [R1] see [R2]
          end else begin
            evt_code = rx_ack_reg ? `TW_ST_SR_ACK : `TW_ST_SR_NACK; // see [R17]
          end
        end
        TX_ACK_S: begin
          evt_set = 1'b1;
          if (!mack_reg) begin
            evt_code = `TW_ST_ST_NACK; // see [R11]
          end else begin
            evt_code = last_reg ? `TW_ST_ST_LAST : `TW_ST_ST_ACK; // see [R11] see [R19]
          end
        end
        default: begin
          evt_set = 1'b0;
        end
      endcase
    end
  end

  // event flag and status; a new event wins over a clear in the same cycle
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      flag_reg <= 1'b0;
      code_reg <= `TW_RST_CODE;
    end else begin
      if (evt_set) begin
        flag_reg <= 1'b1;
        code_reg <= evt_code;
      end else if (flag_clr) begin
        flag_reg <= 1'b0;
      end
    end
  end

  // bus state machine
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      state_reg   <= IDLE_S;
      bit_cnt_reg <= 4'h0;
      shift_reg   <= 8'h00;
      tx_reg      <= 8'hff;
      gc_mode_reg <= 1'b0;
      dir_rd_reg  <= 1'b0;
      rx_ack_reg  <= 1'b0;
      mack_reg    <= 1'b0;
      last_reg    <= 1'b0;
      tx_on_reg   <= 1'b0;
      sda_drv_reg <= 1'b0;
    end else if (!en_reg) begin
      state_reg   <= IDLE_S;
      tx_on_reg   <= 1'b0;
      sda_drv_reg <= 1'b0;
    end else if (c.start) begin
      state_reg   <= ADDR_S;
      bit_cnt_reg <= 4'h0;
      tx_on_reg   <= 1'b0;
      sda_drv_reg <= 1'b0;
    end else if (c.stop) begin
      state_reg   <= IDLE_S;
      tx_on_reg   <= 1'b0;
      sda_drv_reg <= 1'b0;
    end else begin
      case (state_reg)
        ADDR_S: begin
          if (c.scl_rise) begin
            shift_reg   <= {shift_reg[6:0], c.sda};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (c.scl_fall && bit_cnt_reg == `TW_BITS) begin
            // matching runs on bus edges alone, so it works in deep sleep
            if (own_hit || gc_hit) begin // see [R14]
              sda_drv_reg <= 1'b1;
              gc_mode_reg <= !own_hit;
              dir_rd_reg  <= own_hit && shift_reg[0]; // see [R8]
              state_reg   <= ADDR_ACK_S;
            end else begin
              state_reg <= IDLE_S;
            end
          end
        end
        ADDR_ACK_S: begin
          if (c.scl_fall) begin
            sda_drv_reg <= 1'b0;
            bit_cnt_reg <= 4'h0;
            state_reg   <= dir_rd_reg ? TX_DATA_S : RX_DATA_S; // see [R8]
          end
        end
        RX_DATA_S: begin
          if (c.scl_rise) begin
            shift_reg   <= {shift_reg[6:0], c.sda};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (c.scl_fall && bit_cnt_reg == `TW_BITS) begin
            rx_ack_reg  <= ack_en_reg; // see [R1]
            sda_drv_reg <= ack_en_reg;
            state_reg   <= RX_ACK_S;
          end
        end
        RX_ACK_S: begin
          if (c.scl_fall) begin
            sda_drv_reg <= 1'b0;
            bit_cnt_reg <= 4'h0;
            state_reg   <= rx_ack_reg ? RX_DATA_S : DONE_S; // see [R2] see [R17]
          end
        end
        TX_DATA_S: begin
          if (flag_clr && !tx_on_reg) begin
            tx_reg      <= data_reg; // see [R18] see [R19]
            // the ack enable written together with the clear marks the last byte
            last_reg    <= !i_wdata[`TW_CTRL_ACK_EN]; // see [R11]
            tx_on_reg   <= 1'b1;
            sda_drv_reg <= !data_reg[7];
          end else if (c.scl_rise && tx_on_reg) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (c.scl_fall && tx_on_reg) begin
            if (bit_cnt_reg == `TW_BITS) begin
              sda_drv_reg <= 1'b0;
              tx_on_reg   <= 1'b0;
              state_reg   <= TX_ACK_S;
            end else begin
              tx_reg      <= {tx_reg[6:0], 1'b1};
              sda_drv_reg <= !tx_reg[6];
            end
          end
        end
        TX_ACK_S: begin
          if (c.scl_rise) begin
            mack_reg <= !c.sda;
          end else if (c.scl_fall) begin
            bit_cnt_reg <= 4'h0;
            // after the last byte sda stays released: master reads ones
            state_reg   <= (mack_reg && !last_reg) ? TX_DATA_S : DONE_S; // see [R12]
          end
        end
        DONE_S: begin
          if (flag_clr) begin
            state_reg <= IDLE_S; // see [R2] see [R12] see [R17]
          end
        end
        default: begin
          state_reg <= IDLE_S;
        end
      endcase
    end
  end

  // clock stretch while software owns the event; costs one cycle of latency
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      scl_hold_reg <= 1'b0;
    end else begin
      scl_hold_reg <= flag_reg && !flag_clr &&
                      ((state_reg == RX_DATA_S) || (state_reg == TX_DATA_S) ||
                       (state_reg == DONE_S)); // see [R20] see [R15]
    end
  end

  // wake request after a match in deep sleep, held until the flag clears
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      wake_req_reg <= 1'b0;
    end else if (evt_set && state_reg == ADDR_ACK_S && i_deep_sleep) begin
      wake_req_reg <= 1'b1; // see [R14]
    end else if (flag_clr) begin
      wake_req_reg <= 1'b0; // see [R15]
    end
  end

  // bus busy tracking and deferred start request
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      busy_reg        <= 1'b0;
      start_pend_reg  <= 1'b0;
      start_issue_reg <= 1'b0;
    end else begin
      start_issue_reg <= 1'b0;
      if (c.start) begin
        busy_reg <= 1'b1;
      end else if (c.stop) begin
        busy_reg <= 1'b0;
      end
      if (flag_clr && i_wdata[`TW_CTRL_STA] && leaving) begin
        start_pend_reg <= 1'b1; // see [R3]
      end else if (start_pend_reg && !busy_reg && !c.start) begin
        start_pend_reg  <= 1'b0;
        start_issue_reg <= 1'b1; // see [R3]
      end
    end
  end

  // software registers
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      data_reg              <= `TW_RST_DATA;
      own_slave_address_reg <= `TW_RST_OWN_ADDR;
      presc_reg             <= 2'h0;
      ack_en_reg            <= 1'b0;
      sta_reg               <= 1'b0;
      sto_reg               <= 1'b0;
      wcol_reg              <= 1'b0;
      en_reg                <= 1'b0;
      irq_en_reg            <= 1'b0;
    end else begin
      if (state_reg == RX_DATA_S && c.scl_fall && bit_cnt_reg == `TW_BITS &&
          !i_deep_sleep) begin
        data_reg <= shift_reg; // see [R16]
      end else if (i_wr && i_addr == ADDR_W'(`TW_OFF_DATA)) begin
        if (flag_reg) begin
          data_reg <= i_wdata;
          wcol_reg <= 1'b0;
        end else begin
          wcol_reg <= 1'b1;
        end
      end
      if (i_wr && i_addr == ADDR_W'(`TW_OFF_OWN_ADDR)) begin
        own_slave_address_reg <= i_wdata; // see [R6]
      end
      if (i_wr && i_addr == ADDR_W'(`TW_OFF_STATUS)) begin
        presc_reg <= i_wdata[1:0];
      end
      if (wr_ctrl) begin
        ack_en_reg <= i_wdata[`TW_CTRL_ACK_EN]; // see [R7] see [R13]
        sta_reg    <= i_wdata[`TW_CTRL_STA];
        sto_reg    <= i_wdata[`TW_CTRL_STO];
        en_reg     <= i_wdata[`TW_CTRL_EN]; // see [R7]
        irq_en_reg <= i_wdata[`TW_CTRL_IRQ_EN];
      end
    end
  end

  // read data stand one cycle after the strobe, zero otherwise
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      rdata_reg <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        ADDR_W'(`TW_OFF_DATA):     rdata_reg <= data_reg;
        // code low bits are zero, so masking bits 1:0 yields the code
        ADDR_W'(`TW_OFF_STATUS):   rdata_reg <= {code_shown[7:3], 1'b0, presc_reg}; // see [R5]
        ADDR_W'(`TW_OFF_OWN_ADDR): rdata_reg <= own_slave_address_reg;
        ADDR_W'(`TW_OFF_CTRL):     rdata_reg <= {flag_reg, ack_en_reg, sta_reg, sto_reg,
                                                 wcol_reg, en_reg, 1'b0, irq_en_reg};
        default:                   rdata_reg <= 8'h00;
      endcase
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    low_reg <= 1'b0;
  end

  assign o_rdata       = rdata_reg;
  assign o_scl_o       = low_reg;
  assign o_scl_oe      = scl_hold_reg;
  assign o_sda_o       = low_reg;
  assign o_sda_oe      = sda_drv_reg;
  assign o_wake_req    = wake_req_reg;
  assign o_start_issue = start_issue_reg;
endmodule
